// ### verilog/supply_monitor.sv
// supply monitor control, flag, delayed interrupt and wake-up logic
`timescale 1ns/1ns
// Behaviour
// R1 - control bit 4 written 1 switches the detector on
// R2 - control bit 4 cleared powers the analog detector down
// R3 - bits 2..0 pick trip level 2.7/3.0/3.3/3.6/4.0 V; 000-010 reserved
// R4 - control bit 5 is a read-only low supply flag
// R5 - flag goes high whenever the detector is on and the comparator reports supply below threshold
// R6 - control bits 7, 6, 3 read zero and ignore writes
// R7 - detector keeps running in power-down while enabled
// R8 - reference is enabled automatically together with the detector
// R9 - software waits a settle delay after enabling before trusting the flag
// R10 - flag follows every comparator transition without filtering
// R11 - low supply interrupt is a member of multi-function group 2
// R12 - interrupt request raised only after a fixed delay from flag rise
// R13 - in power-down a supply drop sets the interrupt request flag
// R14 - request flag rising in sleep or idle wakes the device
// R15 - software sets the request flag before sleep to avoid wake-up
// R16 - vectoring needs global, low supply and group-2 enables, stack not full
// R17 - servicing clears global enable and group flag, keeps request flag
// R18 - wake-up on request rising edge regardless of enable bits
// R19 - comparator output passes two flip-flops before any use
// R20 - settle and interrupt delays are parameter-loaded restartable counters
module supply_monitor #(
  parameter int SETTLE_COUNT = supply_monitor_pkg::SETTLE_CYCLES,
  parameter int IRQ_COUNT = supply_monitor_pkg::IRQ_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic COMP_LOW,
  input wire logic LOW_POWER_MODE,
  input wire logic STACK_FULL,
  input wire logic SERVICE_ACK,
  output logic DETECTOR_POWER,
  output logic [2:0] TRIP_SELECT,
  output logic VECTOR_REQUEST,
  output logic WAKEUP
);
  localparam int TW = supply_monitor_pkg::TIMER_WIDTH;

  if (SETTLE_COUNT < 1 || SETTLE_COUNT >= (1 << TW)) begin : g_settle_range
    $error("settle count out of range");
  end
  if (IRQ_COUNT < 1 || IRQ_COUNT >= (1 << TW)) begin : g_irq_range
    $error("irq count out of range");
  end

  logic detector_on_q;
  logic [2:0] trip_q;
  logic comp_meta_q;
  logic comp_sync_q;
  logic low_flag_q;
  logic low_flag_prev_q;
  logic irq_req_q;
  logic irq_req_prev_q;
  logic irq_allow_q;
  logic group2_allow_q;
  logic global_allow_q;
  logic group2_req_q;
  logic vector_q;
  logic wakeup_q;
  logic ready_q;
  logic slverr_q;
  logic [31:0] rdata_q;
  logic settled_q;

  logic setup_phase;
  logic access_done;
  logic wr_control;
  logic wr_irq;
  logic addr_hit;
  logic flag_rise;
  logic detector_rise;
  logic irq_timer_done;
  logic settle_done;
  logic irq_busy;
  logic req_rise;
  logic [7:0] control_view;
  logic [7:0] irq_view;
  logic [7:0] status_view;
  logic [TW-1:0] settle_load;
  logic [TW-1:0] irq_load;

  assign settle_load = TW'(SETTLE_COUNT);
  assign irq_load = TW'(IRQ_COUNT);

  // apb phases; the slave answers in the first access cycle, no wait states
  assign setup_phase = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE && ready_q;
  assign wr_control = access_done && PWRITE && ((PADDR & supply_monitor_pkg::ADDR_MASK) ==
                      supply_monitor_pkg::CONTROL_OFFSET);
  assign wr_irq = access_done && PWRITE && ((PADDR & supply_monitor_pkg::ADDR_MASK) ==
                  supply_monitor_pkg::IRQ_OFFSET);
  assign addr_hit = ((PADDR & supply_monitor_pkg::ADDR_MASK) == supply_monitor_pkg::CONTROL_OFFSET) ||
                    ((PADDR & supply_monitor_pkg::ADDR_MASK) == supply_monitor_pkg::IRQ_OFFSET) ||
                    ((PADDR & supply_monitor_pkg::ADDR_MASK) == supply_monitor_pkg::STATUS_OFFSET);

  // control register; only bits 4 and 2..0 are storage
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      detector_on_q <= 1'b0;
      trip_q <= supply_monitor_pkg::CONTROL_RESET[2:0];
    end else if (wr_control) begin
      detector_on_q <= PWDATA[supply_monitor_pkg::DETECTOR_ON_POS]; // [R1] [R2]
      trip_q <= PWDATA[supply_monitor_pkg::TRIP_MSB:supply_monitor_pkg::TRIP_LSB]; // [R3] [R6]
    end
  end

  // comparator is asynchronous to CLK
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= COMP_LOW; // [R19]
      comp_sync_q <= comp_meta_q; // [R19]
    end
  end

  // no hysteresis here: a slowly moving supply may toggle the flag
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      low_flag_q <= 1'b0;
      low_flag_prev_q <= 1'b0;
    end else begin
      low_flag_q <= detector_on_q && comp_sync_q; // [R5] [R10] [R7]
      low_flag_prev_q <= low_flag_q;
    end
  end

  assign flag_rise = low_flag_q && !low_flag_prev_q;
  assign detector_rise = wr_control && PWDATA[supply_monitor_pkg::DETECTOR_ON_POS] && !detector_on_q;

  // settle delay restarts each time the detector is switched on
  delay_timer #(
    .WIDTH(TW)
  ) settle_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .start(detector_rise), // [R20] [R9]
    .cancel(wr_control && !PWDATA[supply_monitor_pkg::DETECTOR_ON_POS]),
    .load_value(settle_load),
    .busy(),
    .done(settle_done)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      settled_q <= 1'b0;
    end else if (detector_rise || (wr_control && !PWDATA[supply_monitor_pkg::DETECTOR_ON_POS])) begin
      settled_q <= 1'b0;
    end else if (settle_done) begin
      settled_q <= 1'b1; // [R9]
    end
  end

  // interrupt delay starts at each flag rise, abandoned if the flag drops
  delay_timer #(
    .WIDTH(TW)
  ) irq_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .start(flag_rise), // [R20] [R12]
    .cancel(!low_flag_q),
    .load_value(irq_load),
    .busy(irq_busy),
    .done(irq_timer_done)
  );

  // request flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_req_q <= 1'b0;
    end else if (irq_timer_done && low_flag_q) begin
      irq_req_q <= 1'b1; // [R12] [R13]
    end else if (wr_irq) begin
      irq_req_q <= PWDATA[supply_monitor_pkg::IRQ_REQ_POS]; // [R15]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_req_prev_q <= 1'b0;
    end else begin
      irq_req_prev_q <= irq_req_q;
    end
  end

  assign req_rise = irq_req_q && !irq_req_prev_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_allow_q <= 1'b0;
      group2_allow_q <= 1'b0;
    end else if (wr_irq) begin
      irq_allow_q <= PWDATA[supply_monitor_pkg::IRQ_ALLOW_POS];
      group2_allow_q <= PWDATA[supply_monitor_pkg::GROUP2_ALLOW_POS];
    end
  end

  // service clears global enable; a software write in the same cycle loses
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      global_allow_q <= 1'b0;
    end else if (SERVICE_ACK && vector_q) begin
      global_allow_q <= 1'b0; // [R17]
    end else if (wr_irq) begin
      global_allow_q <= PWDATA[supply_monitor_pkg::GLOBAL_ALLOW_POS];
    end
  end

  // group flag is set by an allowed member request, cleared by service
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      group2_req_q <= 1'b0;
    end else if (req_rise && irq_allow_q) begin
      group2_req_q <= 1'b1; // [R11]
    end else if (SERVICE_ACK && vector_q) begin
      group2_req_q <= 1'b0; // [R17]
    end else if (wr_irq && !PWDATA[supply_monitor_pkg::GROUP2_REQ_POS]) begin
      group2_req_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      vector_q <= 1'b0;
    end else if (SERVICE_ACK && vector_q) begin
      vector_q <= 1'b0;
    end else begin
      vector_q <= global_allow_q && group2_allow_q && irq_allow_q && group2_req_q && irq_req_q &&
                  !STACK_FULL; // [R16]
    end
  end

  // wake-up ignores all enable bits by design
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wakeup_q <= 1'b0;
    end else begin
      wakeup_q <= req_rise && LOW_POWER_MODE; // [R14] [R18]
    end
  end

  always_comb begin
    control_view = 8'h00; // [R6]
    control_view[supply_monitor_pkg::TRIP_MSB:supply_monitor_pkg::TRIP_LSB] = trip_q;
    control_view[supply_monitor_pkg::DETECTOR_ON_POS] = detector_on_q;
    control_view[supply_monitor_pkg::LOW_FLAG_POS] = low_flag_q; // [R4]
  end

  always_comb begin
    irq_view = 8'h00;
    irq_view[supply_monitor_pkg::IRQ_REQ_POS] = irq_req_q;
    irq_view[supply_monitor_pkg::IRQ_ALLOW_POS] = irq_allow_q;
    irq_view[supply_monitor_pkg::GROUP2_ALLOW_POS] = group2_allow_q;
    irq_view[supply_monitor_pkg::GLOBAL_ALLOW_POS] = global_allow_q;
    irq_view[supply_monitor_pkg::GROUP2_REQ_POS] = group2_req_q;
  end

  always_comb begin
    status_view = 8'h00;
    status_view[supply_monitor_pkg::SETTLED_POS] = settled_q;
    status_view[supply_monitor_pkg::IRQ_PENDING_POS] = irq_busy;
  end

  // read data captured in setup so PRDATA comes from a flip-flop
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= 32'h00000000;
    end else if (setup_phase && !PWRITE) begin
      case (PADDR & supply_monitor_pkg::ADDR_MASK)
        supply_monitor_pkg::CONTROL_OFFSET: begin
          rdata_q <= {24'h000000, control_view};
        end
        supply_monitor_pkg::IRQ_OFFSET: begin
          rdata_q <= {24'h000000, irq_view};
        end
        supply_monitor_pkg::STATUS_OFFSET: begin
          rdata_q <= {24'h000000, status_view};
        end
        default: begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ready_q <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      ready_q <= setup_phase;
      slverr_q <= setup_phase && !addr_hit;
    end
  end

  assign PRDATA = rdata_q;
  assign PREADY = ready_q;
  assign PSLVERR = slverr_q;
  assign DETECTOR_POWER = detector_on_q; // [R2] [R8] [R7]
  assign TRIP_SELECT = trip_q; // [R3]
  assign VECTOR_REQUEST = vector_q;
  assign WAKEUP = wakeup_q;
endmodule

// ### verilog/supply_monitor_pkg.sv
// constants shared by the supply monitor design
package supply_monitor_pkg;
  // register byte offsets
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] IRQ_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'hfc;

  // control register fields
  localparam int TRIP_LSB = 0;
  localparam int TRIP_MSB = 2;
  localparam int DETECTOR_ON_POS = 4;
  localparam int LOW_FLAG_POS = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h17;

  // interrupt register fields
  localparam int IRQ_REQ_POS = 0;
  localparam int IRQ_ALLOW_POS = 1;
  localparam int GROUP2_ALLOW_POS = 2;
  localparam int GLOBAL_ALLOW_POS = 3;
  localparam int GROUP2_REQ_POS = 4;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // status register fields
  localparam int SETTLED_POS = 0;
  localparam int IRQ_PENDING_POS = 1;

  // trip level codes
  localparam logic [2:0] TRIP_2V7 = 3'h3;
  localparam logic [2:0] TRIP_3V0 = 3'h4;
  localparam logic [2:0] TRIP_3V3 = 3'h5;
  localparam logic [2:0] TRIP_3V6 = 3'h6;
  localparam logic [2:0] TRIP_4V0 = 3'h7;
  localparam logic [2:0] TRIP_FIRST_VALID = TRIP_2V7;

  // timing
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_DELAY_NS = 100000;
  localparam int IRQ_DELAY_NS = 45000;
  localparam int SETTLE_CYCLES = (SETTLE_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int IRQ_CYCLES = (IRQ_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int TIMER_WIDTH = 16;
endpackage

// ### verilog/delay_timer.sv
// loadable down counter with a one-cycle expiry pulse
`timescale 1ns/1ns
module delay_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic cancel,
  input wire logic [WIDTH-1:0] load_value,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] count_q;
  logic busy_q;
  logic done_q;

  // refused at elaboration: a one-bit counter cannot tell one from zero
  if (WIDTH < 2) begin : g_width_check
    $error("delay_timer width too small");
  end

  // restart wins over cancel so a fresh start is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      count_q <= load_value;
      busy_q <= 1'b1;
    end else if (cancel) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        busy_q <= 1'b0;
      end else begin
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && !start && !cancel && (count_q <= {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule

// ### tb/supply_far_model.sv
// comparator and interrupt controller stand-in
`timescale 1ns/1ns
module supply_far_model (
  input wire logic clk,
  input wire logic power,
  input wire logic [2:0] trip,
  input var int supply_mv,
  input wire logic vec_req,
  input wire logic ack_en,
  output logic comp_low,
  output logic service_ack
);
  int level_mv;
  always_comb begin
    case (trip)
      3'h3: level_mv = 2700;
      3'h4: level_mv = 3000;
      3'h5: level_mv = 3300;
      3'h6: level_mv = 3600;
      3'h7: level_mv = 4000;
      default: level_mv = 0;
    endcase
  end
  // unpowered comparator reads low, not its last value
  assign comp_low = power && (supply_mv < level_mv);
  always_ff @(posedge clk) service_ack <= vec_req && ack_en;
endmodule

// ### tb/supply_monitor_chk.sv
// port-level assertions for the supply monitor
`timescale 1ns/1ns
module supply_monitor_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic STACK_FULL,
  input wire logic SERVICE_ACK,
  input wire logic DETECTOR_POWER,
  input wire logic [2:0] TRIP_SELECT,
  input wire logic VECTOR_REQUEST,
  input wire logic WAKEUP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic ctl_wr;
  assign ctl_wr = PSEL && PENABLE && PWRITE && PADDR[7:2] == 6'h00;
  AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
  AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY) else $error("stray error");
  AST_POWER_WRITE: assert property (ctl_wr && PREADY |=> DETECTOR_POWER == $past(PWDATA[4]))
    else $error("power bit not written");
  AST_TRIP_WRITE: assert property (ctl_wr && PREADY |=> TRIP_SELECT == $past(PWDATA[2:0]))
    else $error("trip field not written");
  AST_CTRL_HOLD: assert property (!ctl_wr |=> $stable(DETECTOR_POWER) && $stable(TRIP_SELECT))
    else $error("control changed without write");
  AST_STACK_BLOCK: assert property (STACK_FULL |=> !VECTOR_REQUEST) else $error("vector while full");
  AST_SERVICE_CLEAR: assert property (VECTOR_REQUEST && SERVICE_ACK |=> !VECTOR_REQUEST [*2])
    else $error("vector not cleared");
  AST_WAKE_PULSE: assert property (WAKEUP |=> !WAKEUP) else $error("wake pulse too long");
endmodule
bind supply_monitor supply_monitor_chk u_chk (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PREADY, .PSLVERR, .STACK_FULL, .SERVICE_ACK, .DETECTOR_POWER, .TRIP_SELECT, .VECTOR_REQUEST, .WAKEUP);

// ### tb/supply_monitor_tb.sv
// self-checking bench for the supply monitor
`timescale 1ns/1ns
module supply_monitor_tb;
  localparam int IRQ_N = 20;
  logic CLK, RST_N, PSEL, PENABLE, PWRITE, LOW_POWER_MODE, STACK_FULL, ack_en, er;
  logic PREADY, PSLVERR, COMP_LOW, SERVICE_ACK, DETECTOR_POWER, VECTOR_REQUEST, WAKEUP;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [2:0] TRIP_SELECT;
  int mv, cnt, w0;
  int err_count = 0;
  int n_compared = 0;
  int wakes = 0;
  logic [7:0] wr_v [10] = '{8'hff, 8'h13, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h17, 8'h07, 8'h12};
  logic [7:0] ex_v [10] = '{8'h17, 8'h33, 8'h13, 8'h34, 8'h35, 8'h36, 8'h37, 8'h17, 8'h07, 8'h12};
  int mv_v [10] = '{5000, 2600, 2800, 2900, 3200, 3500, 3900, 4100, 2000, 2000};
  supply_monitor #(.SETTLE_COUNT(8), .IRQ_COUNT(IRQ_N)) u_supply_monitor (.CLK, .RST_N, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .COMP_LOW, .LOW_POWER_MODE, .STACK_FULL,
    .SERVICE_ACK, .DETECTOR_POWER, .TRIP_SELECT, .VECTOR_REQUEST, .WAKEUP);
  supply_far_model u_supply_far_model (.clk(CLK), .power(DETECTOR_POWER), .trip(TRIP_SELECT), .supply_mv(mv),
    .vec_req(VECTOR_REQUEST), .ack_en, .comp_low(COMP_LOW), .service_ack(SERVICE_ACK));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) if (WAKEUP === 1'b1) wakes <= wakes + 1;
  task automatic close_out;
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  // no limit of its own on ready: a stuck slave is caught by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic trip;
    mv <= 5000;
    repeat (8) @(posedge CLK);
    mv <= 2600;
    repeat (40) @(posedge CLK);
  endtask
  initial begin
    RST_N = 1'b0;
    {PSEL, PENABLE, PWRITE, LOW_POWER_MODE, STACK_FULL, ack_en} = 6'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    mv = 5000;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (int i = 0; i < 10; i++) begin
      mv <= mv_v[i];
      apb(1'b1, 8'h00, {24'h0, wr_v[i]});
      repeat (12) @(posedge CLK); // settle before trusting the flag
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {24'h0, ex_v[i]});
    end
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[0], 1'b1);
    mv <= 5000;
    apb(1'b1, 8'h00, 32'h13);
    apb(1'b1, 8'h04, 32'h0e);
    LOW_POWER_MODE <= 1'b1;
    STACK_FULL <= 1'b1;
    mv <= 2600;
    cnt = 0;
    while (WAKEUP !== 1'b1 && cnt < 200) begin
      @(posedge CLK);
      cnt++;
    end
    chk(cnt >= IRQ_N && cnt < 200, 1'b1);
    repeat (4) @(posedge CLK);
    chk(VECTOR_REQUEST, 1'b0);
    STACK_FULL <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(VECTOR_REQUEST, 1'b1);
    ack_en <= 1'b1;
    repeat (4) @(posedge CLK);
    ack_en <= 1'b0;
    chk(VECTOR_REQUEST, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h07);
    apb(1'b1, 8'h04, 32'h0);
    w0 = wakes;
    trip();
    chk(wakes, w0 + 1);
    apb(1'b1, 8'h04, 32'h0); // clear first so the preset really makes the difference
    apb(1'b1, 8'h04, 32'h1); // preset request to mask wake
    repeat (4) @(posedge CLK); // the software set itself wakes once; let it pass
    w0 = wakes;
    trip();
    chk(wakes, w0);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
  initial begin
    #(40 * 5000);
    err_count++;
    close_out();
  end
endmodule
